// ---- hw/pfc_host.sv ----
// host controller driving the flash control, address and data pins
`timescale 1ns/1ps
module pfc_host
    import pfc_pkg::*;
#(
    parameter int PULSE_CYC = WRITE_CYC
) (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic req_valid_i, // request strobe
    output logic req_ready_o, // controller idle
    input pfc_req_t req_i, // operation, address, data
    input wire logic temp_unprotect_i, // hold reset at high voltage except while a reset op drives reset low
    input wire logic accel_i, // hold accel pin at high voltage around plain writes
    output logic done_o, // one-cycle completion pulse
    output logic [7:0] rdata_o, // captured read data
    output pfc_ctl_t ctl_o, // flash control pins
    output logic [ADDR_W-1:0] addr_o, // flash address pins
    output logic [7:0] dq_o, // data out
    output logic dq_oe_n_o, // data drive enable, low drives
    input wire logic [7:0] dq_i, // data in
    input wire logic ready_busy_n_i // device ready, low busy
);
    //////////////////////////////////////////////////////////////////////
    // reset released through two flops
    logic rst_s1, rst_s2;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    //////////////////////////////////////////////////////////////////////
    pfc_state_t state, next_state;
    pfc_req_t cur, next_cur;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [7:0] rdata, next_rdata;
    logic done, next_done;

    // counter load for a phase of n cycles
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    // ops that end with the device driving the data bus
    function automatic logic is_read_op(input pfc_op_t op);
        is_read_op = (op == PFC_OP_READ) || (op == PFC_OP_VERIFY) ||
            (op == PFC_OP_ID);
    endfunction

    // ops that pulse write enable with output enable at high voltage
    function automatic logic is_hv_write(input pfc_op_t op);
        is_hv_write = (op == PFC_OP_PROTECT) ||
            (op == PFC_OP_UNPROTECT);
    endfunction

    // ops that need the id address line at high voltage
    function automatic logic needs_id_hv(input pfc_op_t op);
        needs_id_hv = is_hv_write(op) || (op == PFC_OP_VERIFY) ||
            (op == PFC_OP_ID);
    endfunction

    // op codes that have a bus sequence behind them
    function automatic logic is_known_op(input pfc_op_t op);
        is_known_op = is_read_op(op) || is_hv_write(op) ||
            (op == PFC_OP_WRITE) || (op == PFC_OP_RESET);
    endfunction

    // address with the fixed mode bits of each high-voltage op
    function automatic logic [ADDR_W-1:0] mode_addr(
        input pfc_op_t op,
        input logic [ADDR_W-1:0] addr
    );
        mode_addr = addr;
        if (op == PFC_OP_PROTECT) begin
            mode_addr[6] = 1'b0;
        end else if (op == PFC_OP_UNPROTECT) begin
            mode_addr[6] = 1'b1;
        end else if (op == PFC_OP_VERIFY) begin
            mode_addr[1] = 1'b1;
            mode_addr[0] = 1'b0;
            mode_addr[6] = 1'b0;
        end else if (op == PFC_OP_ID) begin
            mode_addr[1] = 1'b0;
            mode_addr[6] = 1'b0;
        end
    endfunction

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_cnt = cnt;
        next_rdata = rdata;
        next_done = 1'b0;
        case (state)
            PFC_IDLE: begin
                if (req_valid_i) begin
                    next_cur = req_i;
                    if (req_i.op == PFC_OP_RESET) begin
                        next_state = PFC_RESET;
                        next_cnt = cyc(RST_PULSE_CYC);
                    end else if (!is_known_op(req_i.op)) begin
                        // unknown ops finish at once with the control pins left idle
                        next_state = PFC_DONE;
                    end else begin
                        next_state = PFC_SETUP;
                        next_cnt = '0;
                    end
                end
            end
            PFC_SETUP: begin
                next_state = PFC_PULSE;
                if (is_read_op(cur.op)) begin
                    next_cnt = cyc(READ_CYC);
                end else begin
                    next_cnt = cyc(PULSE_CYC);
                end
            end
            PFC_PULSE: begin
                if (cnt == '0) begin
                    if (is_read_op(cur.op)) begin
                        next_rdata = dq_i;
                    end
                    next_state = PFC_DONE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            PFC_RESET: begin
                if (cnt == '0) begin
                    next_state = PFC_RECOVER;
                    next_cnt = cyc(RST_RECOVER_CYC);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            PFC_RECOVER: begin
                // wait out recovery and any busy internal reset
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (ready_busy_n_i) begin
                    next_state = PFC_DONE;
                end
            end
            PFC_DONE: begin
                next_done = 1'b1;
                next_state = PFC_IDLE;
            end
            default: next_state = PFC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= PFC_IDLE;
            cur <= '0;
            cnt <= '0;
            rdata <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            cnt <= next_cnt;
            rdata <= next_rdata;
            done <= next_done;
        end
    end

    //////////////////////////////////////////////////////////////////////
    pfc_ctl_t next_ctl;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0] next_dq;
    logic next_dq_oe_n;
    logic active, is_wr, is_rd, hv_wr;

    // pins are registered from state, one cycle behind it
    always_comb begin
        active = (state == PFC_PULSE);
        is_wr = (cur.op == PFC_OP_WRITE);
        hv_wr = is_hv_write(cur.op);
        is_rd = is_read_op(cur.op);
        next_ctl.select_n = !(state == PFC_SETUP || active);
        next_ctl.output_enable_n = !(active && is_rd);
        next_ctl.write_enable_n = !(active && (is_wr || hv_wr));
        next_ctl.reset_n = !(state == PFC_RESET);
        // oe and id line high voltage only while their own op runs
        next_ctl.oe_high_voltage = hv_wr && (state != PFC_IDLE);
        next_ctl.id_line_high_voltage = (state != PFC_IDLE) &&
            needs_id_hv(cur.op);
        next_ctl.reset_high_voltage = temp_unprotect_i &&
            (state != PFC_RESET);
        // accel level only around a plain write, never for reads
        next_ctl.accel_high_voltage = accel_i && is_wr &&
            (state == PFC_SETUP || active);
        next_addr = mode_addr(cur.op, cur.addr);
        next_dq = cur.data;
        // data driven from setup so it settles before write enable
        next_dq_oe_n = !((state == PFC_SETUP || active) && is_wr);
    end

    always_ff @(posedge sys_clk_i or negedge rst_s2) begin
        if (!rst_s2) begin
            ctl_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            addr_o <= '0;
            dq_o <= '0;
            dq_oe_n_o <= 1'b1;
        end else begin
            ctl_o <= next_ctl;
            addr_o <= next_addr;
            dq_o <= next_dq;
            dq_oe_n_o <= next_dq_oe_n;
        end
    end

    assign req_ready_o = (state == PFC_IDLE);
    assign done_o = done;
    assign rdata_o = rdata;
endmodule

// ---- hw/pfc_pkg.sv ----
// package for the parallel flash host-side bus controller
package pfc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_ACCESS_NS = 70;
    localparam int SELECT_ACCESS_NS = 70;
    localparam int RESET_PULSE_MIN_NS = 500;
    localparam int RESET_HIGH_TO_READ_NS = 50;
    localparam int READ_CYC =
        (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_PULSE_CYC =
        (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_RECOVER_CYC =
        (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = 4;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 22;

    typedef enum logic [3:0] {
        PFC_OP_READ = 4'h0,
        PFC_OP_WRITE = 4'h1,
        PFC_OP_RESET = 4'h2,
        PFC_OP_PROTECT = 4'h3,
        PFC_OP_UNPROTECT = 4'h4,
        PFC_OP_VERIFY = 4'h5,
        PFC_OP_ID = 4'h6
    } pfc_op_t;

    typedef struct packed {
        pfc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } pfc_req_t;

    typedef struct packed {
        logic select_n;
        logic output_enable_n;
        logic write_enable_n;
        logic reset_n;
        logic oe_high_voltage;
        logic id_line_high_voltage;
        logic reset_high_voltage;
        logic accel_high_voltage;
    } pfc_ctl_t;

    typedef enum logic [5:0] {
        PFC_IDLE = 6'b000001,
        PFC_SETUP = 6'b000010,
        PFC_PULSE = 6'b000100,
        PFC_RESET = 6'b001000,
        PFC_RECOVER = 6'b010000,
        PFC_DONE = 6'b100000
    } pfc_state_t;
endpackage

// ---- tb/pfc_flash_model.sv ----
// behavioural flash device on the far side of the host pins
`timescale 1ns/1ps
module pfc_flash_model
    import pfc_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3c, // arbitrary value
    parameter int READY_NS = 1000 // internal reset time while busy
) (
    input pfc_ctl_t ctl_i, // control pins
    input wire logic [ADDR_W-1:0] addr_i, // address pins
    input wire logic [7:0] dq_i, // bus level
    output logic [7:0] dq_o, // device drive
    output logic ready_busy_n_o // low busy
);
    logic [7:0] mem [256];
    logic [63:0] prot = '0;
    logic [7:0] last = 8'h00, v, wd;
    logic [ADDR_W-1:0] wa;
    pfc_ctl_t wc = '1;
    logic busy = 1'b0;
    logic rst_busy = 1'b0;
    initial foreach (mem[i]) mem[i] = 8'hff;
    assign ready_busy_n_o = ~(busy | rst_busy);
    // reset during a program keeps busy for the internal reset
    always @(negedge ctl_i.reset_n) if (busy) begin
        rst_busy = 1'b1;
        #READY_NS rst_busy = 1'b0;
    end
    always @* begin
        if (ctl_i.id_line_high_voltage)
            v = addr_i[1] ? {7'h0, prot[addr_i[21:16]]}
                : addr_i[0] ? DEV_CODE : MFR_CODE;
        else
            v = mem[addr_i[7:0]];
        // released bus shows inverse of last value
        if (ctl_i.select_n || ctl_i.output_enable_n || !ctl_i.reset_n)
            dq_o = ~last;
        else begin
            dq_o = v;
            last = v;
        end
    end
    always @* if (!ctl_i.write_enable_n && !ctl_i.select_n) begin
        wa = addr_i;
        wd = dq_i;
        wc = ctl_i;
    end
    always @(posedge ctl_i.write_enable_n) begin
        if (!wc.select_n && wc.reset_n) begin
            if (wc.oe_high_voltage) begin
                if (wa[6]) prot = '0;
                else prot[wa[21:16]] = 1'b1;
            end else if (!prot[wa[21:16]] || wc.reset_high_voltage
                         || wc.accel_high_voltage) begin
                mem[wa[7:0]] = wd;
                busy = 1'b1;
                #50 busy = 1'b0;
            end
        end
    end
endmodule

// ---- tb/pfc_host_properties.sv ----
// assertions on the flash host pins
`timescale 1ns/1ps
module pfc_host_properties
    import pfc_pkg::*;
#(
    parameter int PULSE_CYC = WRITE_CYC
) (
    input wire logic sys_clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic temp_unprotect_i, // temp unprotect
    input wire logic accel_i, // accel request
    input pfc_ctl_t ctl_o, // control pins
    input wire logic [ADDR_W-1:0] addr_o, // address pins
    input wire logic dq_oe_n_o // data drive, low drives
);
    localparam int PW = PULSE_CYC - 1;
    wire oe = ctl_o.output_enable_n;
    wire we = ctl_o.write_enable_n;
    wire rs = ctl_o.reset_n;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    property p_wr; !we |-> oe && !ctl_o.select_n; endproperty
    a_wr: assert property (p_wr) else $error("bad write pins");
    property p_rd; !oe |-> we && dq_oe_n_o && !ctl_o.select_n; endproperty
    a_rd: assert property (p_rd) else $error("bad read pins");
    property p_rdl; $fell(oe) |-> !oe [*7] ##1 oe; endproperty
    a_rdl: assert property (p_rdl) else $error("read length");
    property p_wrl; $fell(we) |-> ##PW !we ##1 we; endproperty
    a_wrl: assert property (p_wrl) else $error("write length");
    property p_rst; $fell(rs) |-> ##49 !rs ##1 rs; endproperty
    a_rst: assert property (p_rst) else $error("reset width");
    property p_tup;
        $past(rst_n_i, 4) && rs |->
            ctl_o.reset_high_voltage == $past(temp_unprotect_i);
    endproperty
    a_tup: assert property (p_tup) else $error("unprotect level");
    property p_tuprs; !rs |-> !ctl_o.reset_high_voltage; endproperty
    a_tuprs: assert property (p_tuprs) else $error("reset hv");
    property p_acc;
        ctl_o.accel_high_voltage |->
            oe && !ctl_o.select_n && $past(accel_i);
    endproperty
    a_acc: assert property (p_acc) else $error("accel level");
    property p_accw;
        !we && !ctl_o.oe_high_voltage |->
            ctl_o.accel_high_voltage == $past(accel_i);
    endproperty
    a_accw: assert property (p_accw) else $error("accel write");
    property p_id;
        !oe && ctl_o.id_line_high_voltage |-> !addr_o[6];
    endproperty
    a_id: assert property (p_id) else $error("id address");
endmodule

bind pfc_host pfc_host_properties #(.PULSE_CYC(PULSE_CYC)) chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ctl_o(ctl_o),
    .temp_unprotect_i(temp_unprotect_i), .accel_i(accel_i),
    .addr_o(addr_o), .dq_oe_n_o(dq_oe_n_o));

// ---- tb/testbench.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module testbench
    import pfc_pkg::*;
;
    localparam logic [7:0] MFR = 8'h5a; // arbitrary value
    localparam logic [7:0] DEV = 8'h3c; // arbitrary value
    localparam int RDY_NS = 1000; // internal reset time of the model
    logic clk = 0, rst_n = 0, vld = 0, tup = 0, acc = 0, rdy, done;
    logic dq_oe_n, rb_n;
    logic [7:0] rdata, hdq, ddq, d, exp_mem [256];
    logic [ADDR_W-1:0] addr, a;
    pfc_req_t req = '0;
    pfc_ctl_t ctl;
    int err_total = 0, n_compared = 0;
    time t0;
    wire [7:0] bus = dq_oe_n ? ddq : hdq;
    pfc_host pfc_host_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
        .req_valid_i(vld), .req_ready_o(rdy), .req_i(req),
        .temp_unprotect_i(tup), .accel_i(acc), .done_o(done),
        .rdata_o(rdata), .ctl_o(ctl), .addr_o(addr), .dq_o(hdq),
        .dq_oe_n_o(dq_oe_n), .dq_i(bus), .ready_busy_n_i(rb_n));
    pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .READY_NS(RDY_NS))
        pfc_flash_model_inst (
        .ctl_i(ctl), .addr_i(addr), .dq_i(bus), .dq_o(ddq),
        .ready_busy_n_o(rb_n));
    initial forever #5 clk = ~clk;
    task automatic run(input pfc_op_t op, input logic [21:0] ad,
                       input logic [7:0] dt);
        int n = 0;
        @(negedge clk);
        while (!rdy) @(negedge clk);
        req = '{op, ad, dt};
        vld = 1;
        @(negedge clk);
        vld = 0;
        while (!done && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) err_total++;
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr_rd(input logic [21:0] ad, input logic [7:0] dt);
        run(PFC_OP_WRITE, ad, dt);
        run(PFC_OP_READ, ad, 8'h00);
        `CHK(rdata, exp_mem[ad[7:0]])
    endtask
    ////////////////////////////////////////
    initial begin
        #50us;
        err_total++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h708b));
        foreach (exp_mem[i]) exp_mem[i] = 8'hff;
        repeat (12) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            a = {14'h0, 8'($urandom)};
            d = i == 0 ? 8'h00 : 8'($urandom);
            exp_mem[a[7:0]] = d;
            wr_rd(a, d);
        end
        $display("test rw done");
        for (int i = 0; i < 2; i++) begin
            run(PFC_OP_ID, {21'h0, i[0]}, 8'h00);
            `CHK(rdata, i ? DEV : MFR)
        end
        $display("test id done");
        a = 22'h050010;
        run(PFC_OP_PROTECT, a, 8'h00);
        run(PFC_OP_VERIFY, a, 8'h00);
        `CHK(rdata, 8'h01)
        wr_rd(a, 8'h12);
        tup = 1;
        exp_mem[8'h10] = 8'h34;
        wr_rd(a, 8'h34);
        tup = 0;
        acc = 1;
        exp_mem[8'h10] = 8'h56;
        wr_rd(a, 8'h56);
        acc = 0;
        run(PFC_OP_UNPROTECT, a, 8'h00);
        run(PFC_OP_VERIFY, a, 8'h00);
        `CHK(rdata, 8'h00)
        $display("test protect done");
        exp_mem[8'h21] = 8'h77;
        run(PFC_OP_WRITE, 22'h21, 8'h77);
        t0 = $time;
        run(PFC_OP_RESET, 22'h0, 8'h00);
        `CHK(($time - t0) > RDY_NS, 1'b1)
        run(PFC_OP_READ, 22'h21, 8'h00);
        `CHK(rdata, 8'h77)
        $display("test reset done");
        wrap_up();
    end
endmodule
